// [hdl/hbc_pkg.sv]
// Shared constants and types for the acknowledge daisy-chain bus port.
// Assumes one 200 MHz clock shared by both ends of the link.
package hbc_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int KIND_W = 2;
    localparam int GRP_W  = 2;
    localparam int CNT_W  = 4;
    localparam int SYN_W  = 4;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 5;
    localparam int REQ_EXTRA_NS   = 30;
    localparam int REQ_LIMIT_CYC  = 2 + REQ_EXTRA_NS / CLK_PERIOD_NS;
    localparam int SEL_SETUP_NS   = 10;
    localparam int SEL_HOLD_NS    = 4;
    localparam int SEL_MIN_NS     = CLK_PERIOD_NS + SEL_SETUP_NS
                                    + SEL_HOLD_NS;
    localparam logic [CNT_W-1:0] SEL_MIN_CYC =
        CNT_W'((SEL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    // ------------------------------------------------------------------
    // Addresses and codes
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] EOS_ADDR = 8'h7f;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

    localparam logic [KIND_W-1:0] KIND_READ  = 2'h0;
    localparam logic [KIND_W-1:0] KIND_WRITE = 2'h1;
    localparam logic [KIND_W-1:0] KIND_SVC   = 2'h2;

    localparam logic [GRP_W-1:0] GRP_NONE = 2'h0;
    localparam logic [GRP_W-1:0] GRP_RX   = 2'h1;
    localparam logic [GRP_W-1:0] GRP_TX   = 2'h2;
    localparam logic [GRP_W-1:0] GRP_MDM  = 2'h3;

    // Synchroniser lanes on the device side
    localparam int SYN_STB = 0;
    localparam int SYN_CS  = 1;
    localparam int SYN_ACK = 2;
    localparam int SYN_RW  = 3;
    localparam logic [SYN_W-1:0] SYN_IDLE = 4'hf;

    // ------------------------------------------------------------------
    // State machines
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        DEV_IDLE   = 5'b00001,
        DEV_LATCH  = 5'b00010,
        DEV_DELAY  = 5'b00100,
        DEV_ANSWER = 5'b01000,
        DEV_PASS   = 5'b10000
    } hbc_dev_state_t;

    typedef enum logic [3:0] {
        HST_IDLE    = 4'b0001,
        HST_SETUP   = 4'b0010,
        HST_STROBE  = 4'b0100,
        HST_RELEASE = 4'b1000
    } hbc_hst_state_t;

endpackage

// [hdl/hbc_bus_if.sv]
// Interface joining the host end and one chained device end.
// Wire levels are resolved here from the drive enables (pull-up on ack).
`timescale 1ns/1ps
`default_nettype none
interface hbc_bus_if;
    import hbc_pkg::*;

    logic              data_strobe_n;
    logic              chip_select_n;
    logic              read_not_write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] host_data;
    logic              host_data_oe_n;
    logic [DATA_W-1:0] dev_data;
    logic              dev_data_oe_n;
    logic              ack_drive;
    logic              ack_oe_n;
    logic              chain_select_in_n;
    logic              chain_select_out_n;
    logic              rx_service_request_n;
    logic              tx_service_request_n;
    logic              line_change_request_n;
    logic [DATA_W-1:0] data_bus;
    logic              transfer_ack_n;

    // ------------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------------
    assign data_bus = !dev_data_oe_n ? dev_data :
                      (!host_data_oe_n ? host_data : DATA_ZERO);
    assign transfer_ack_n = ack_oe_n ? 1'b1 : ack_drive;

    modport dev (
        input  data_strobe_n, chip_select_n, read_not_write, addr,
        input  data_bus, chain_select_in_n,
        output dev_data, dev_data_oe_n, ack_drive, ack_oe_n,
        output chain_select_out_n, rx_service_request_n,
        output tx_service_request_n, line_change_request_n
    );

    modport host (
        output data_strobe_n, chip_select_n, read_not_write, addr,
        output host_data, host_data_oe_n, chain_select_in_n,
        input  data_bus, transfer_ack_n,
        input  rx_service_request_n, tx_service_request_n,
        input  line_change_request_n
    );
endinterface
`default_nettype wire

// [hdl/hbc_device_end.sv]
// Device end of the parallel bus port with acknowledge daisy chain.
// Assumes host strobes arrive unclocked; addr and write data stay steady
// while a cycle is active, as the host keeps them.
//
// Overview of operation
// - Unmatched acknowledge cycle drives chain pass
// - While passing, no data drive, no acknowledge
// - Pass output returns high after cycle ends
// - Host ends each cycle before next
// - Single device: select held one period plus
// - Chain: select held until it reaches last
// - Host holds address until acknowledge seen
// - Request withdrawn soon after service acknowledge
// - Request reasserted soon after end-of-service write
// - All host strobes synchronised internally
// - Acknowledge cycles use select-in, not chip select
// - Service acknowledge returns the service vector
`timescale 1ns/1ps
`default_nettype none
module hbc_device_end (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    hbc_bus_if.dev                          bus,
    input  wire logic [hbc_pkg::ADDR_W-1:0] rx_match_id,
    input  wire logic [hbc_pkg::ADDR_W-1:0] tx_match_id,
    input  wire logic [hbc_pkg::ADDR_W-1:0] mdm_match_id,
    input  wire logic                       rx_need,
    input  wire logic                       tx_need,
    input  wire logic                       mdm_need,
    input  wire logic [hbc_pkg::DATA_W-1:0] service_vector,
    input  wire logic                       ack_delay_select,
    input  wire logic [hbc_pkg::DATA_W-1:0] reg_rdata,
    output logic      [hbc_pkg::ADDR_W-1:0] reg_addr,
    output logic      [hbc_pkg::DATA_W-1:0] reg_wdata,
    output logic                            reg_wr_pulse
);
    import hbc_pkg::*;

    // ------------------------------------------------------------------
    // Strobe synchronisers
    // ------------------------------------------------------------------
    logic [SYN_W-1:0] raw_in;
    logic [SYN_W-1:0] s1_ff;
    logic [SYN_W-1:0] s2_ff;
    logic [SYN_W-1:0] s3_ff;
    logic [SYN_W-1:0] clean_ff;
    logic [SYN_W-1:0] nxt_clean;

    assign raw_in = {bus.read_not_write, bus.chain_select_in_n,
                     bus.chip_select_n, bus.data_strobe_n};
    // A lane changes once stages two and three agree
    assign nxt_clean = (s2_ff & s3_ff) | (clean_ff & (s2_ff ^ s3_ff));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_ff    <= SYN_IDLE;
            s2_ff    <= SYN_IDLE;
            s3_ff    <= SYN_IDLE;
            clean_ff <= SYN_IDLE;
        end else begin
            s1_ff    <= raw_in;
            s2_ff    <= s1_ff;
            s3_ff    <= s2_ff;
            clean_ff <= nxt_clean;
        end
    end

    // ------------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------------
    function automatic logic [GRP_W-1:0] match_grp(
        input logic [ADDR_W-1:0] a,
        input logic [2:0]        live
    );
        logic [GRP_W-1:0] g;
        g = GRP_NONE;
        if (live[0] && a == rx_match_id) begin
            g = GRP_RX;
        end else if (live[1] && a == tx_match_id) begin
            g = GRP_TX;
        end else if (live[2] && a == mdm_match_id) begin
            g = GRP_MDM;
        end
        return g;
    endfunction

    hbc_dev_state_t   state_ff;
    hbc_dev_state_t   nxt_state;
    logic [2:0]       withdrawn_ff;
    logic [2:0]       nxt_withdrawn;
    logic [GRP_W-1:0] grp_ff;
    logic             svc_ff;
    logic             rd_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] data_ff;
    logic             data_oe_n_ff;
    logic             ack_drive_ff;
    logic             ack_oe_n_ff;
    logic             pass_n_ff;
    logic [2:0]       req_n_ff;
    logic             wr_pulse_ff;

    wire       stb_on  = !clean_ff[SYN_STB];
    wire       cs_on   = !clean_ff[SYN_CS];
    wire       ack_on  = !clean_ff[SYN_ACK];
    wire       is_read = clean_ff[SYN_RW];
    wire [2:0] need    = {mdm_need, tx_need, rx_need};
    wire [2:0] live    = need & ~withdrawn_ff;
    wire       cyc_reg = stb_on && cs_on && !ack_on;
    wire       cyc_svc = stb_on && ack_on && !cs_on;
    wire       cyc_end = !stb_on || (!cs_on && !ack_on);
    wire [GRP_W-1:0] hit_grp = match_grp(bus.addr, live);
    wire       eos_wr  = cyc_reg && !is_read && bus.addr == EOS_ADDR;
    wire       start   = (state_ff == DEV_IDLE) && (cyc_reg || cyc_svc);
    wire       answering = (state_ff == DEV_ANSWER);
    wire       passing = (state_ff == DEV_PASS);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            DEV_IDLE: begin
                if (cyc_svc && hit_grp == GRP_NONE) begin
                    nxt_state = DEV_PASS;
                end else if (cyc_svc || cyc_reg) begin
                    nxt_state = DEV_LATCH;
                end
            end
            DEV_LATCH: begin
                if (cyc_end) begin
                    nxt_state = DEV_IDLE;
                end else if (ack_delay_select) begin
                    nxt_state = DEV_DELAY;
                end else begin
                    nxt_state = DEV_ANSWER;
                end
            end
            DEV_DELAY: begin
                nxt_state = cyc_end ? DEV_IDLE : DEV_ANSWER;
            end
            DEV_ANSWER: begin
                if (cyc_end) begin
                    nxt_state = DEV_IDLE;
                end
            end
            DEV_PASS: begin
                if (cyc_end) begin
                    nxt_state = DEV_IDLE;
                end
            end
            default: nxt_state = DEV_IDLE;
        endcase
    end

    // Withdraw on acknowledge, rearm on end-of-service write
    always_comb begin
        nxt_withdrawn = withdrawn_ff;
        if (eos_wr && state_ff == DEV_IDLE) begin
            nxt_withdrawn = 3'h0;
        end
        if (answering && svc_ff) begin
            case (grp_ff)
                GRP_RX:  nxt_withdrawn[0] = 1'b1;
                GRP_TX:  nxt_withdrawn[1] = 1'b1;
                GRP_MDM: nxt_withdrawn[2] = 1'b1;
                default: nxt_withdrawn = withdrawn_ff;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff     <= DEV_IDLE;
            withdrawn_ff <= 3'h0;
            grp_ff       <= GRP_NONE;
            svc_ff       <= 1'b0;
            rd_ff        <= 1'b0;
            addr_ff      <= '0;
            wdata_ff     <= '0;
            wr_pulse_ff  <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            withdrawn_ff <= nxt_withdrawn;
            wr_pulse_ff  <= start && cyc_reg && !is_read;
            if (start) begin
                grp_ff   <= hit_grp;
                svc_ff   <= cyc_svc;
                rd_ff    <= is_read || cyc_svc;
                addr_ff  <= bus.addr;
                wdata_ff <= bus.data_bus;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_ff <= '0;
        end else if (state_ff == DEV_LATCH) begin
            data_ff <= svc_ff ? service_vector : reg_rdata;
        end
    end

    // Pins: data and acknowledge only while answering, never passing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_oe_n_ff <= 1'b1;
            ack_drive_ff <= 1'b1;
            ack_oe_n_ff  <= 1'b1;
            pass_n_ff    <= 1'b1;
            req_n_ff     <= 3'h7;
        end else begin
            data_oe_n_ff <= !(nxt_state == DEV_ANSWER && rd_ff);
            ack_drive_ff <= !(nxt_state == DEV_ANSWER);
            // Drive high for one cycle after release, then float
            ack_oe_n_ff  <= !(nxt_state == DEV_ANSWER || answering);
            pass_n_ff    <= !(nxt_state == DEV_PASS);
            req_n_ff     <= ~(need & ~nxt_withdrawn);
        end
    end

    assign bus.dev_data              = data_ff;
    assign bus.dev_data_oe_n         = data_oe_n_ff;
    assign bus.ack_drive             = ack_drive_ff;
    assign bus.ack_oe_n              = ack_oe_n_ff;
    assign bus.chain_select_out_n    = pass_n_ff;
    assign bus.rx_service_request_n  = req_n_ff[0];
    assign bus.tx_service_request_n  = req_n_ff[1];
    assign bus.line_change_request_n = req_n_ff[2];
    assign reg_addr                  = addr_ff;
    assign reg_wdata                 = wdata_ff;
    assign reg_wr_pulse              = wr_pulse_ff;
    wire unused_pass = passing;

endmodule
`default_nettype wire

// [hdl/hbc_host_end.sv]
// Host end: runs read, write and service acknowledge cycles on the bus.
// Assumes the device answers every cycle with transfer_ack_n.
`timescale 1ns/1ps
`default_nettype none
module hbc_host_end (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    hbc_bus_if.host                         bus,
    input  wire logic                       cmd_valid,
    output logic                            cmd_ready,
    input  wire logic [hbc_pkg::KIND_W-1:0] cmd_kind,
    input  wire logic [hbc_pkg::ADDR_W-1:0] cmd_addr,
    input  wire logic [hbc_pkg::DATA_W-1:0] cmd_wdata,
    output logic                            rsp_valid,
    output logic      [hbc_pkg::DATA_W-1:0] rsp_data
);
    import hbc_pkg::*;

    // ------------------------------------------------------------------
    // Acknowledge synchroniser
    // ------------------------------------------------------------------
    logic ak1_ff;
    logic ak2_ff;
    logic ak3_ff;
    logic ak_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ak1_ff <= 1'b1;
            ak2_ff <= 1'b1;
            ak3_ff <= 1'b1;
            ak_ff  <= 1'b1;
        end else begin
            ak1_ff <= bus.transfer_ack_n;
            ak2_ff <= ak1_ff;
            ak3_ff <= ak2_ff;
            if (ak2_ff == ak3_ff) begin
                ak_ff <= ak3_ff;
            end
        end
    end

    // ------------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------------
    hbc_hst_state_t    state_ff;
    hbc_hst_state_t    nxt_state;
    logic [KIND_W-1:0] kind_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [CNT_W-1:0]  hold_ff;
    logic              rsp_ff;

    wire is_svc   = (kind_ff == KIND_SVC);
    wire is_write = (kind_ff == KIND_WRITE);
    wire strobing = (state_ff == HST_STROBE);
    wire held     = (hold_ff >= SEL_MIN_CYC);
    wire acked    = strobing && !ak_ff && held;

    assign cmd_ready = (state_ff == HST_IDLE);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            HST_IDLE:    if (cmd_valid) nxt_state = HST_SETUP;
            HST_SETUP:   nxt_state = HST_STROBE;
            HST_STROBE:  if (acked) nxt_state = HST_RELEASE;
            HST_RELEASE: if (ak_ff) nxt_state = HST_IDLE;
            default:     nxt_state = HST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= HST_IDLE;
            kind_ff  <= KIND_READ;
            addr_ff  <= '0;
            wdata_ff <= '0;
            rdata_ff <= '0;
            hold_ff  <= '0;
            rsp_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            rsp_ff   <= (state_ff == HST_RELEASE) && ak_ff;
            hold_ff  <= strobing ? (held ? hold_ff : hold_ff + CNT_ONE)
                                 : '0;
            if (cmd_ready && cmd_valid) begin
                kind_ff  <= cmd_kind;
                addr_ff  <= cmd_addr;
                wdata_ff <= cmd_wdata;
            end
            if (acked) begin
                rdata_ff <= bus.data_bus;
            end
        end
    end

    assign bus.addr              = addr_ff;
    assign bus.host_data         = wdata_ff;
    assign bus.host_data_oe_n    = !(strobing && is_write);
    assign bus.read_not_write    = !is_write;
    assign bus.data_strobe_n     = !strobing;
    assign bus.chip_select_n     = !(strobing && !is_svc);
    assign bus.chain_select_in_n = !(strobing && is_svc);
    assign rsp_valid             = rsp_ff;
    assign rsp_data              = rdata_ff;

endmodule
`default_nettype wire

// [verification/hbc_link_checker.sv]
// Checker: timing relations on the first host/device link.
// Assumes the bench ties it to the link signals and keeps all needs set.
`timescale 1ns/1ps
`default_nettype none
module hbc_link_checker (
    input wire logic                       clk,
    input wire logic                       sys_rst,
    input wire logic                       data_strobe_n,
    input wire logic                       chip_select_n,
    input wire logic                       read_not_write,
    input wire logic [hbc_pkg::ADDR_W-1:0] addr,
    input wire logic                       chain_select_in_n,
    input wire logic                       chain_select_out_n,
    input wire logic                       transfer_ack_n,
    input wire logic                       dev_data_oe_n,
    input wire logic                       rx_service_request_n,
    input wire logic                       tx_service_request_n,
    input wire logic                       line_change_request_n
);
    import hbc_pkg::*;
    localparam int REQ_MAX = 8;
    wire [2:0] reqs_n;
    assign reqs_n = {line_change_request_n, tx_service_request_n,
                     rx_service_request_n};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_pass_no_drive: assert property (
        !chain_select_out_n |-> transfer_ack_n && dev_data_oe_n)
        else $error("Pass output low while device answers");
    a_pass_release: assert property (
        $rose(chain_select_in_n) |-> ##[0:8] chain_select_out_n)
        else $error("Pass output stays low after cycle end");
    a_req_withdraw: assert property (
        $fell(transfer_ack_n) && !chain_select_in_n |-> ##[0:REQ_MAX]
        ($rose(reqs_n[0]) || $rose(reqs_n[1]) || $rose(reqs_n[2])))
        else $error("Request not withdrawn after service answer");
    a_req_rearm: assert property (
        $fell(data_strobe_n) && !chip_select_n && !read_not_write
        && addr == EOS_ADDR |-> ##[0:REQ_MAX] reqs_n == 3'h0)
        else $error("Request not reasserted after end of service");
    a_host_steady: assert property (
        !data_strobe_n && $past(data_strobe_n) == 1'b0
        && $past(transfer_ack_n) == 1'b1 |-> $stable({addr,
        read_not_write, chip_select_n, chain_select_in_n}))
        else $error("Host changed cycle signals before answer");
    a_svc_no_cs: assert property (
        !chain_select_in_n |-> chip_select_n)
        else $error("Chip select low during acknowledge cycle");
    a_sel_min_hold: assert property (
        $fell(chain_select_in_n) |-> !chain_select_in_n [*4])
        else $error("Select-in pulse too short");
    a_sel_until_ack: assert property (
        $rose(chain_select_in_n) |-> $past(transfer_ack_n) == 1'b0)
        else $error("Select-in released before answer");
    a_no_early_ack: assert property (
        $fell(data_strobe_n) |-> transfer_ack_n [*4])
        else $error("Answer present at or soon after strobe");
    a_end_release: assert property (
        $rose(data_strobe_n) |-> ##[1:8] transfer_ack_n && dev_data_oe_n)
        else $error("Bus not released after strobe removal");
    a_svc_data: assert property (
        !transfer_ack_n && !chain_select_in_n |-> !dev_data_oe_n)
        else $error("Service answer without data drive");

    c_svc: cover property ($fell(transfer_ack_n) && !chain_select_in_n);
    c_eos: cover property ($fell(data_strobe_n) && addr == EOS_ADDR);
    c_read: cover property ($fell(transfer_ack_n) && read_not_write
        && !chip_select_n);
endmodule
`default_nettype wire

// [verification/test_host_bus_ack_daisy_chain.sv]
// Bench: host end against device end, plus a hand-driven second link.
// Assumes package, interface and both ends are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_host_bus_ack_daisy_chain;
    import hbc_pkg::*;

    typedef struct packed {
        logic [KIND_W-1:0] kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wd;
        logic [DATA_W-1:0] exp;
        logic              dly;
        logic [2:0]        reqs;
    } hbc_row_t;

    logic              clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              cmd_valid = 1'b0;
    logic              cmd_ready;
    logic [KIND_W-1:0] cmd_kind = KIND_READ;
    logic [ADDR_W-1:0] cmd_addr = 8'h00;
    logic [DATA_W-1:0] cmd_wdata = 8'h00;
    logic              rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic [ADDR_W-1:0] rx_id = 8'h11;
    logic [ADDR_W-1:0] tx_id = 8'h22;
    logic [ADDR_W-1:0] md_id = 8'h33;
    logic              need = 1'b1;
    logic [DATA_W-1:0] svec = 8'ha5;
    logic              dly = 1'b0;
    logic [ADDR_W-1:0] reg_addr;
    logic [ADDR_W-1:0] reg_addr2;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr_pulse;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    int                failures = 0;
    int                n_tests = 0;
    hbc_row_t          rows [6];

    hbc_bus_if bus ();
    hbc_bus_if bus2 ();

    always #2.5 clk = ~clk;

    // ------------------------------------------------------------------
    // Ends under test
    // ------------------------------------------------------------------
    hbc_host_end u_hbc_host_end (
        .clk(clk), .sys_rst(sys_rst), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    hbc_device_end u_hbc_device_end (
        .clk(clk), .sys_rst(sys_rst), .bus(bus), .rx_match_id(rx_id),
        .tx_match_id(tx_id), .mdm_match_id(md_id), .rx_need(need),
        .tx_need(need), .mdm_need(need), .service_vector(svec),
        .ack_delay_select(dly), .reg_rdata(reg_addr ^ 8'h3c),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr_pulse(reg_wr_pulse));
    hbc_device_end u_hbc_device_end_2 (
        .clk(clk), .sys_rst(sys_rst), .bus(bus2), .rx_match_id(rx_id),
        .tx_match_id(tx_id), .mdm_match_id(md_id), .rx_need(need),
        .tx_need(need), .mdm_need(need), .service_vector(svec),
        .ack_delay_select(dly), .reg_rdata(reg_addr2 ^ 8'h3c),
        .reg_addr(reg_addr2), .reg_wdata(), .reg_wr_pulse());
    hbc_link_checker u_hbc_link_checker (
        .clk(clk), .sys_rst(sys_rst), .data_strobe_n(bus.data_strobe_n),
        .chip_select_n(bus.chip_select_n),
        .read_not_write(bus.read_not_write), .addr(bus.addr),
        .chain_select_in_n(bus.chain_select_in_n),
        .chain_select_out_n(bus.chain_select_out_n),
        .transfer_ack_n(bus.transfer_ack_n),
        .dev_data_oe_n(bus.dev_data_oe_n),
        .rx_service_request_n(bus.rx_service_request_n),
        .tx_service_request_n(bus.tx_service_request_n),
        .line_change_request_n(bus.line_change_request_n));

    always @(posedge clk) begin
        if (reg_wr_pulse === 1'b1) begin
            wr_addr <= reg_addr;
            wr_data <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (failures == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic run(input hbc_row_t r);
        int i;
        @(negedge clk);
        dly = r.dly;
        cmd_valid = 1'b1;
        cmd_kind = r.kind;
        cmd_addr = r.addr;
        cmd_wdata = r.wd;
        @(negedge clk);
        cmd_valid = 1'b0;
        for (i = 0; i < 200 && rsp_valid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 200)
            failures++;
    endtask

    task automatic cyc2(input logic [ADDR_W-1:0] a, input logic pass);
        int i;
        @(negedge clk);
        bus2.addr = a;
        @(negedge clk);
        bus2.data_strobe_n = 1'b0;
        bus2.chain_select_in_n = 1'b0;
        for (i = 0; i < 12 && bus2.chain_select_out_n === 1'b1
             && bus2.transfer_ack_n === 1'b1; i++)
            @(negedge clk);
        repeat (4) begin
            @(negedge clk);
            check(16'({bus2.chain_select_out_n, bus2.transfer_ack_n,
                       bus2.dev_data_oe_n}),
                  pass ? 16'h3 : 16'h4);
        end
        bus2.data_strobe_n = 1'b1;
        bus2.chain_select_in_n = 1'b1;
        for (i = 0; i < 8 && (bus2.chain_select_out_n
             & bus2.transfer_ack_n) !== 1'b1; i++)
            @(negedge clk);
        repeat (2) @(negedge clk);
        check(16'({bus2.chain_select_out_n, bus2.transfer_ack_n,
                   bus2.dev_data_oe_n}), 16'h7);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rows[0] = '{KIND_WRITE, 8'h10, 8'h5a, 8'h00, 1'b0, 3'h0};
        rows[1] = '{KIND_READ, 8'h21, 8'h00, 8'h21 ^ 8'h3c, 1'b1, 3'h0};
        rows[2] = '{KIND_SVC, 8'h11, 8'h00, 8'ha5, 1'b0, 3'h1};
        rows[3] = '{KIND_SVC, 8'h22, 8'h00, 8'ha5, 1'b1, 3'h3};
        rows[4] = '{KIND_SVC, 8'h33, 8'h00, 8'ha5, 1'b0, 3'h7};
        rows[5] = '{KIND_WRITE, EOS_ADDR, 8'h00, 8'h00, 1'b1, 3'h0};
        bus2.data_strobe_n = 1'b1;
        bus2.chip_select_n = 1'b1;
        bus2.read_not_write = 1'b1;
        bus2.addr = 8'h00;
        bus2.host_data = 8'h00;
        bus2.host_data_oe_n = 1'b1;
        bus2.chain_select_in_n = 1'b1;
        repeat (3) @(negedge clk);
        check(16'({bus.transfer_ack_n, bus.chain_select_out_n,
                   bus.rx_service_request_n, bus.dev_data_oe_n}),
              16'hf);
        sys_rst = 1'b0;
        foreach (rows[r]) begin
            run(rows[r]);
            if (rows[r].kind == KIND_WRITE && rows[r].addr != EOS_ADDR)
                check({wr_addr, wr_data}, {rows[r].addr, rows[r].wd});
            else if (rows[r].kind != KIND_WRITE)
                check(16'(rsp_data), 16'(rows[r].exp));
            check(16'({bus.line_change_request_n, bus.tx_service_request_n,
                       bus.rx_service_request_n}),
                  16'(rows[r].reqs));
            check(16'(cmd_ready), 16'h1);
        end
        cyc2(8'h99, 1'b1);
        cyc2(8'h11, 1'b0);
        check(16'(bus2.rx_service_request_n), 16'h1);
        cyc2(8'h11, 1'b1);
        conclude();
    end

    initial begin
        #20000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
